// >>> src/mdsu_pkg.sv
// package of constants for the multiply, divide and shift datapath
// assumes: a single core clock, operands driven by the core sequencer
package mdsu_pkg;

    localparam int DATA_W    = 16;
    localparam int MUL_OP_W  = 17;
    localparam int PROD_W    = 34;
    localparam int DIV_STEPS = 19;
    localparam int SHAMT_W   = 5;
    localparam int MAX_SHIFT = 16;
    localparam int STEP_W    = 5;

    localparam logic [1:0] MUL_UU = 2'h0;
    localparam logic [1:0] MUL_SS = 2'h1;
    localparam logic [1:0] MUL_SU = 2'h2;
    localparam logic [1:0] MUL_US = 2'h3;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        DIV_IDLE = 3'b001,
        DIV_RUN  = 3'b010,
        DIV_DONE = 3'b100
    } div_state_t;

endpackage : mdsu_pkg

// >>> src/mdsu_shifter.sv
// single-cycle barrel shifter, left or right, 0 to 16 positions
// assumes: combinational use inside the datapath
`timescale 1ns/1ps
module mdsu_shifter
#(
    parameter int WIDTH = 16
)
(
    // operand and control
    input  wire logic [WIDTH-1:0]                  data_i,
    input  wire logic [$clog2(WIDTH+1)-1:0]        amount_i,
    input  wire logic                              right_i,
    input  wire logic                              arith_i,
    // result
    output logic      [WIDTH-1:0]                  result_o
);
    logic signed [2*WIDTH-1:0] ext;
    logic        [2*WIDTH-1:0] sh;

    always_comb
    begin
        ext = {{WIDTH{arith_i & data_i[WIDTH-1]}}, data_i};
        if (amount_i > ($clog2(WIDTH+1))'(WIDTH))
        begin
            sh = right_i ? {2*WIDTH{ext[2*WIDTH-1]}} : '0;
        end
        else if (right_i)
        begin
            sh = ext >>> amount_i;
        end
        else
        begin
            sh = ext << amount_i;
        end
        result_o = sh[WIDTH-1:0];
    end
endmodule : mdsu_shifter

// >>> src/mdsu_datapath.sv
// multiply, divide and shift datapath of a 16-bit core
// assumes: the sequencer repeats the divide step under a repeat count and
// holds the step request low while an interrupt is being served
`timescale 1ns/1ps

// Summary of operation
// - 17x17 multiplier gives the full product in one cycle.
// - multiply modes: signed, unsigned, and both mixed orders.
// - each 16-bit operand gets sign or zero extension by its own signedness.
// - divider handles 16/16 and 32/16 integer division.
// - one divide step per repeated issue; sequencer uses a repeat count.
// - a whole divide takes 19 steps, first to last.
// - between steps all divide state is held, so interrupts lose nothing.
// - shifter moves a word left or right 0 to 16 places in one cycle.
module mdsu_datapath
#(
    parameter int WIDTH = 16
)
(
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    // multiplier
    input  wire logic [WIDTH-1:0]           mul_a_i,
    input  wire logic [WIDTH-1:0]           mul_b_i,
    input  wire logic [1:0]                 mul_mode_i,
    output logic      [2*WIDTH-1:0]         mul_prod_o,
    // divider
    input  wire logic                       div_step_i,
    input  wire logic                       div_start_i,
    input  wire logic                       div_long_i,
    input  wire logic                       div_signed_i,
    input  wire logic [2*WIDTH-1:0]         div_dividend_i,
    input  wire logic [WIDTH-1:0]           div_divisor_i,
    input  wire logic [3:0]                 div_qdst_i,
    input  wire logic [3:0]                 div_rdst_i,
    output logic                            div_busy_o,
    output logic                            div_done_o,
    output logic      [WIDTH-1:0]           div_quot_o,
    output logic      [WIDTH-1:0]           div_rem_o,
    output logic      [3:0]                 div_qdst_o,
    output logic      [3:0]                 div_rdst_o,
    // shifter
    input  wire logic [WIDTH-1:0]           sh_data_i,
    input  wire logic [$clog2(WIDTH+1)-1:0] sh_amount_i,
    input  wire logic                       sh_right_i,
    input  wire logic                       sh_arith_i,
    output logic      [WIDTH-1:0]           sh_result_o
);
    if (WIDTH != mdsu_pkg::DATA_W)
    begin : g_width_check
        $error("datapath width must be 16");
    end

    //------------------------------------------------------------
    // multiplier
    //------------------------------------------------------------
    logic signed [WIDTH:0]     mul_ax;
    logic signed [WIDTH:0]     mul_bx;
    logic signed [2*WIDTH+1:0] mul_full;

    always_comb
    begin
        mul_ax   = {(mul_mode_i == mdsu_pkg::MUL_SS || mul_mode_i == mdsu_pkg::MUL_SU)
                    & mul_a_i[WIDTH-1], mul_a_i};
        mul_bx   = {(mul_mode_i == mdsu_pkg::MUL_SS || mul_mode_i == mdsu_pkg::MUL_US)
                    & mul_b_i[WIDTH-1], mul_b_i};
        mul_full = mul_ax * mul_bx;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mul_prod_o <= mdsu_pkg::RESET_WORD;
        end
        else
        begin
            mul_prod_o <= mul_full[2*WIDTH-1:0];
        end
    end

    //------------------------------------------------------------
    // divider
    //------------------------------------------------------------
    mdsu_pkg::div_state_t state;
    logic [mdsu_pkg::STEP_W-1:0] step;
    logic [2*WIDTH-1:0]          quo;
    logic [WIDTH:0]              rem;
    logic [WIDTH-1:0]            dvs;
    logic                        neg_q;
    logic                        neg_r;
    logic [WIDTH:0]              trial;
    logic [2*WIDTH-1:0]          mag_dd;
    logic [WIDTH-1:0]            mag_ds;
    logic [WIDTH-1:0]            quo_fix;
    logic [WIDTH-1:0]            rem_fix;
    logic                        dd_neg;
    logic                        ds_neg;
    localparam logic [mdsu_pkg::STEP_W-1:0] LAST_STEP =
        mdsu_pkg::STEP_W'(mdsu_pkg::DIV_STEPS - 1);

    always_comb
    begin
        dd_neg = div_signed_i & (div_long_i ? div_dividend_i[2*WIDTH-1]
                                            : div_dividend_i[WIDTH-1]);
        ds_neg = div_signed_i & div_divisor_i[WIDTH-1];
        mag_dd = div_dividend_i;
        if (!div_long_i)
        begin
            mag_dd = {{WIDTH{dd_neg}}, div_dividend_i[WIDTH-1:0]};
        end
        if (dd_neg)
        begin
            mag_dd = -mag_dd;
        end
        mag_ds = ds_neg ? -div_divisor_i : div_divisor_i;
        trial  = {rem[WIDTH-1:0], quo[2*WIDTH-1]} - {1'b0, dvs};
        quo_fix = neg_q ? -quo[WIDTH-1:0] : quo[WIDTH-1:0];
        rem_fix = neg_r ? -rem[WIDTH-1:0] : rem[WIDTH-1:0];
    end

    // state changes only on a step request; otherwise everything holds
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= mdsu_pkg::DIV_IDLE;
            step  <= '0;
            quo   <= '0;
            rem   <= '0;
            dvs   <= '0;
            neg_q <= 1'b0;
            neg_r <= 1'b0;
            div_qdst_o <= 4'h0;
            div_rdst_o <= 4'h0;
        end
        else if (div_step_i)
        begin
            case (state)
                mdsu_pkg::DIV_IDLE, mdsu_pkg::DIV_DONE:
                begin
                    if (div_start_i)
                    begin
                        state <= mdsu_pkg::DIV_RUN;
                        step  <= mdsu_pkg::STEP_W'(1);
                        // high word seeds the remainder, low word is shifted in
                        quo   <= {mag_dd[WIDTH-1:0], {WIDTH{1'b0}}};
                        rem   <= {1'b0, mag_dd[2*WIDTH-1:WIDTH]};
                        dvs   <= mag_ds;
                        neg_q <= dd_neg ^ ds_neg;
                        neg_r <= dd_neg;
                        div_qdst_o <= div_qdst_i;
                        div_rdst_o <= div_rdst_i;
                    end
                    else
                    begin
                        state <= mdsu_pkg::DIV_IDLE;
                    end
                end
                mdsu_pkg::DIV_RUN:
                begin
                    step <= step + 1'b1;
                    if (step >= mdsu_pkg::STEP_W'(2) && step <= mdsu_pkg::STEP_W'(WIDTH + 1))
                    begin
                        // one restoring step per issue, 16 quotient bits for 2..17
                        if (!trial[WIDTH])
                        begin
                            rem <= {1'b0, trial[WIDTH-1:0]};
                            quo <= {quo[2*WIDTH-2:0], 1'b1};
                        end
                        else
                        begin
                            rem <= {1'b0, rem[WIDTH-2:0], quo[2*WIDTH-1]};
                            quo <= {quo[2*WIDTH-2:0], 1'b0};
                        end
                    end
                    if (step == LAST_STEP)
                    begin
                        state <= mdsu_pkg::DIV_DONE;
                    end
                end
                default:
                begin
                    state <= mdsu_pkg::DIV_IDLE;
                end
            endcase
        end
    end

    // results latched on the last step
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_quot_o <= '0;
            div_rem_o  <= '0;
            div_done_o <= 1'b0;
        end
        else
        begin
            div_done_o <= div_step_i && state == mdsu_pkg::DIV_RUN
                          && step == LAST_STEP;
            if (div_step_i && state == mdsu_pkg::DIV_RUN && step == LAST_STEP)
            begin
                div_quot_o <= quo_fix;
                div_rem_o  <= rem_fix;
            end
        end
    end

    assign div_busy_o = (state == mdsu_pkg::DIV_RUN);

    //------------------------------------------------------------
    // shifter
    //------------------------------------------------------------
    logic [WIDTH-1:0] sh_next;

    mdsu_shifter #(.WIDTH(WIDTH)) u_shifter
    (
        .data_i   (sh_data_i),
        .amount_i (sh_amount_i),
        .right_i  (sh_right_i),
        .arith_i  (sh_arith_i),
        .result_o (sh_next)
    );

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sh_result_o <= '0;
        end
        else
        begin
            sh_result_o <= sh_next;
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_run_stalled;
        div_busy_o && !div_step_i;
    endsequence

    property p_mul_ss;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_mode_i == mdsu_pkg::MUL_SS |=> $signed(mul_prod_o) ==
            $signed($past(mul_a_i)) * $signed($past(mul_b_i));
    endproperty
    a_mul_ss: assert property (p_mul_ss) else $error("signed product wrong");

    property p_mul_uu;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_mode_i == mdsu_pkg::MUL_UU |=> mul_prod_o == $past(mul_a_i) * $past(mul_b_i);
    endproperty
    a_mul_uu: assert property (p_mul_uu) else $error("unsigned product wrong");

    property p_mul_su;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_mode_i == mdsu_pkg::MUL_SU |=> $signed(mul_prod_o) ==
            $signed({$past(mul_a_i[WIDTH-1]), $past(mul_a_i)})
            * $signed({1'b0, $past(mul_b_i)});
    endproperty
    a_mul_su: assert property (p_mul_su) else $error("mixed product a signed wrong");

    property p_mul_us;
        @(posedge clk_i) disable iff (!rst_n_i)
        mul_mode_i == mdsu_pkg::MUL_US |=> $signed(mul_prod_o) ==
            $signed({1'b0, $past(mul_a_i)})
            * $signed({$past(mul_b_i[WIDTH-1]), $past(mul_b_i)});
    endproperty
    a_mul_us: assert property (p_mul_us) else $error("mixed product b signed wrong");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_run_stalled |=> $stable(quo) && $stable(rem) && $stable(step);
    endproperty
    a_hold: assert property (p_hold) else $error("divide state lost while paused");

    property p_done_len;
        @(posedge clk_i) disable iff (!rst_n_i)
        div_done_o |-> $past(div_step_i) && $past(step) == LAST_STEP;
    endproperty
    a_done_len: assert property (p_done_len) else $error("divide not 19 steps");

    property p_no_step_no_move;
        @(posedge clk_i) disable iff (!rst_n_i)
        !div_step_i |=> $stable(state);
    endproperty
    a_no_step_no_move: assert property (p_no_step_no_move) else $error("state moved");

endmodule : mdsu_datapath

// >>> tb/mdsu_seq_model.sv
// core sequencer model: issues the divide step under a repeat count
// assumes: a go pulse from the bench, operands held by the bench
`timescale 1ns/1ps
module mdsu_seq_model
(
    // clock and control
    input  wire logic clk_i,
    input  wire logic go_i,
    input  wire logic [31:0] hold_i,
    // divide issue
    output logic      step_o,
    output logic      start_o,
    output int        issued_o
);
    initial
    begin
        step_o   = 1'b0;
        start_o  = 1'b0;
        issued_o = 0;
        forever
        begin
            @(posedge clk_i);
            if (go_i)
            begin
                issued_o <= 0;
                for (int i = 0; i < mdsu_pkg::DIV_STEPS; i++)
                begin
                    if (i == hold_i)
                    begin
                        step_o  <= 1'b0;
                        start_o <= 1'b0;
                        repeat (3) @(posedge clk_i);
                    end
                    step_o   <= 1'b1;
                    start_o  <= (i == 0);
                    issued_o <= i + 1;
                    @(posedge clk_i);
                end
                step_o  <= 1'b0;
                start_o <= 1'b0;
            end
        end
    end
endmodule : mdsu_seq_model

// >>> tb/tb.sv
// testbench of the multiply, divide and shift datapath
// assumes: the sequencer model drives the divide step inputs
`timescale 1ns/1ps
module tb;
    logic        clk_i, rst_n_i, go;
    logic [15:0] mul_a_i, mul_b_i, div_divisor_i, div_quot_o, div_rem_o;
    logic [15:0] sh_data_i, sh_result_o;
    logic [1:0]  mul_mode_i;
    logic [31:0] mul_prod_o, div_dividend_i;
    logic        div_step_i, div_start_i, div_long_i, div_signed_i, div_busy_o, div_done_o;
    logic [3:0]  div_qdst_i, div_rdst_i, div_qdst_o, div_rdst_o;
    logic [4:0]  sh_amount_i;
    logic        sh_right_i, sh_arith_i;
    int          hold, issued, err_total, checks_done;

    mdsu_datapath uut (.clk_i, .rst_n_i, .mul_a_i, .mul_b_i, .mul_mode_i, .mul_prod_o,
        .div_step_i, .div_start_i, .div_long_i, .div_signed_i, .div_dividend_i,
        .div_divisor_i, .div_qdst_i, .div_rdst_i, .div_busy_o, .div_done_o, .div_quot_o,
        .div_rem_o, .div_qdst_o, .div_rdst_o, .sh_data_i, .sh_amount_i, .sh_right_i,
        .sh_arith_i, .sh_result_o);
    mdsu_seq_model seq (.clk_i(clk_i), .go_i(go), .hold_i(hold), .step_o(div_step_i),
        .start_o(div_start_i), .issued_o(issued));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    function automatic logic [31:0] mul_ref(input logic [1:0] m, input logic [15:0] a, b);
        logic signed [16:0] ea, eb;
        logic signed [33:0] p;
        ea = {a[15] & (m == mdsu_pkg::MUL_SS || m == mdsu_pkg::MUL_SU), a};
        eb = {b[15] & (m == mdsu_pkg::MUL_SS || m == mdsu_pkg::MUL_US), b};
        p = ea * eb;
        return p[31:0];
    endfunction : mul_ref

    task automatic test_mul();
        logic [15:0] ops [6] = '{16'hFFFF, 16'hFFFF, 16'h8000, 16'h7FFF, 16'h0003, 16'hFFFE};
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 3; k++)
            begin
                @(posedge clk_i);
                mul_a_i    <= ops[2*k];
                mul_b_i    <= ops[2*k+1];
                mul_mode_i <= m[1:0];
                @(posedge clk_i);
                #1;
                check(mul_prod_o, mul_ref(m[1:0], ops[2*k], ops[2*k+1]));
            end
    endtask : test_mul

    task automatic test_shift();
        int          amts [5] = '{0, 1, 15, 16, 20};
        logic [15:0] d = 16'h8421;
        logic [15:0] e;
        for (int m = 0; m < 3; m++)
            for (int k = 0; k < 5; k++)
            begin
                @(posedge clk_i);
                sh_data_i   <= d;
                sh_amount_i <= amts[k][4:0];
                sh_right_i  <= (m != 0);
                sh_arith_i  <= (m == 2);
                @(posedge clk_i);
                #1;
                if (m == 0)
                    e = d << amts[k];
                else if (m == 1)
                    e = d >> amts[k];
                else
                    e = $signed(d) >>> amts[k];
                check(sh_result_o, e);
            end
    endtask : test_shift

    task automatic test_div(input logic lg, sg, input logic [31:0] dd,
                            input logic [15:0] dv, input int h, input logic [3:0] qd);
        longint nu, de, q, r;
        int     idle, late, busy_n;
        nu = lg ? (sg ? longint'($signed(dd)) : longint'(dd))
                : (sg ? longint'($signed(dd[15:0])) : longint'(dd[15:0]));
        de = sg ? longint'($signed(dv)) : longint'(dv);
        q = nu / de;
        r = nu % de;
        idle = 0;
        late = 0;
        busy_n = 0;
        @(posedge clk_i);
        div_long_i     <= lg;
        div_signed_i   <= sg;
        div_dividend_i <= dd;
        div_divisor_i  <= dv;
        div_qdst_i     <= qd;
        div_rdst_i     <= ~qd;
        hold           <= h;
        go             <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        for (int n = 0; n < 60 && div_done_o !== 1'b1; n++)
        begin
            @(posedge clk_i);
            #1;
            if (div_busy_o === 1'b1)
                busy_n++;
            if (div_busy_o === 1'b1 && div_step_i === 1'b0 && issued < 19)
                idle++;
            if (issued == 19 && div_step_i === 1'b0 && div_done_o !== 1'b1)
                late++;
        end
        check(div_done_o, 1'b1);
        check(issued, 19);
        check(late <= 1, 1'b1);
        check(idle, (h > 0 && h < 19) ? 3 : 0);
        check(busy_n, (h > 0 && h < 19) ? 21 : 18);
        check({div_rem_o, div_quot_o}, {r[15:0], q[15:0]});
        check({div_rdst_o, div_qdst_o}, {~qd, qd});
    endtask : test_div

    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        conclude();
    end

    initial
    begin
        {mul_a_i, mul_b_i, mul_mode_i, div_long_i, div_signed_i} = '0;
        {div_dividend_i, div_divisor_i, div_qdst_i, div_rdst_i} = '0;
        {sh_data_i, sh_amount_i, sh_right_i, sh_arith_i} = '0;
        {rst_n_i, go} = 2'h0;
        hold = 19;
        err_total = 0;
        checks_done = 0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        test_mul();
        test_shift();
        test_div(1'b0, 1'b0, 32'h1234_FFFF, 16'h0007, 5, 4'h1);
        test_div(1'b0, 1'b1, 32'h0000_8001, 16'h0003, 18, 4'h2);
        test_div(1'b1, 1'b0, 32'h0012_3456, 16'h0100, 0, 4'h3);
        test_div(1'b1, 1'b1, 32'hFFFF_8000, 16'h0007, 19, 4'h4);
        conclude();
    end
endmodule : tb
